// ### core/ext_irq_map.svh
// register map, field positions and reset values of the pin interrupt block
// assumes: word-aligned AHB-Lite register slots, 32-bit data
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

// =====================================================================
// byte offsets
`define OFS_SENSE_CONTROL 8'h00
`define OFS_LINE_ENABLE 8'h04
`define OFS_LINE_FLAGS 8'h08
`define OFS_GROUP_ENABLE 8'h0C
`define OFS_GROUP_FLAGS 8'h10
`define OFS_MASK_TWO 8'h14
`define OFS_MASK_ONE 8'h18
`define OFS_MASK_ZERO 8'h1C
`define OFS_IRQ_STATUS 8'h20
`define OFS_IRQ_MASK 8'h24
`define OFS_PIN_STATE 8'h28

// =====================================================================
// field positions
`define SENSE_ZERO_LSB 0
`define SENSE_ONE_LSB 2
`define BIT_LINE_ZERO 0
`define BIT_LINE_ONE 1
`define BIT_GROUP_ZERO 0
`define BIT_GROUP_ONE 1
`define BIT_GROUP_TWO 2

// =====================================================================
// implemented widths and reset values
`define SENSE_BITS 4
`define LINE_BITS 2
`define GROUP_BITS 3
`define MASK_ONE_BITS 7
`define SRC_BITS 5
`define PIN_BITS 25
`define RST_BYTE 8'h00
`define RST_SRC 5'h00

// =====================================================================
// positions inside the sampled pin vector
`define PIN_LINE_ZERO 0
`define PIN_LINE_ONE 1
`define PIN_G0_LSB 2
`define PIN_G0_MSB 9
`define PIN_G1_LSB 10
`define PIN_G1_MSB 16
`define PIN_G2_LSB 17
`define PIN_G2_MSB 24

`endif

// ### core/ext_irq_pkg.sv
// types shared by the pin interrupt block and its surroundings
// assumes: nothing beyond a SystemVerilog compiler
package ext_irq_pkg;

  // sense selection of an external line
  typedef enum logic [1:0] {
    SENSE_LOW = 2'b00,
    SENSE_ANY = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } sense_t;

  // interrupt source numbers, also the bit order of the request vector
  typedef enum logic [2:0] {
    SRC_LINE_ZERO = 3'b000,
    SRC_LINE_ONE = 3'b001,
    SRC_GROUP_ZERO = 3'b010,
    SRC_GROUP_ONE = 3'b011,
    SRC_GROUP_TWO = 3'b100
  } src_t;

endpackage : ext_irq_pkg

// ### core/ext_and_pin_change_irq.sv
// external line and pin change interrupt detector with AHB-Lite registers
// assumes: pins are asynchronous to i_core_clk; the core acknowledges a
// serviced source with a one-cycle pulse; single word AHB transfers
// Functional notes
// - line one sense: low, change, fall, rise
// - line zero uses the same sense encoding
// - sample lines; pulses of two clocks caught
// - line request needs enable and global flag
// - pins trigger even when driven as outputs
// - matching edge sets that line's flag
// - flag clears on dispatch or written one
// - level mode flag always reads cleared
// - each enabled set flag requests own vector
// - group enables gate groups two, one, zero
// - group two mask bits enable single pins
// - change on enabled pin sets group flag
// - group flag clears on dispatch or one
// - unused register bits read zero, ignore writes
// - level and pin change wake without clock
// - level mode requests while line stays low
`timescale 1ns/1ps
`include "ext_irq_map.svh"

module ext_and_pin_change_irq (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic [31:0] o_hrdata,
  output logic o_hresp,
  input wire logic i_ext_line_zero,
  input wire logic i_ext_line_one,
  input wire logic [7:0] i_group_zero_pins,
  input wire logic [6:0] i_group_one_pins,
  input wire logic [7:0] i_group_two_pins,
  input wire logic i_global_int_en,
  input wire logic i_ack_valid,
  input wire ext_irq_pkg::src_t i_ack_src,
  output logic [4:0] o_req,
  output logic o_async_wake,
  output logic o_irq
);
  import ext_irq_pkg::*;

  // =====================================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n;

  // asynchronous assert, two-flop release
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // =====================================================================
  // registers
  logic [`SENSE_BITS-1:0] sense_control_reg;
  logic [`LINE_BITS-1:0] line_enable_reg;
  logic [`LINE_BITS-1:0] line_flags_reg;
  logic [`GROUP_BITS-1:0] group_enable_reg;
  logic [`GROUP_BITS-1:0] group_flags_reg;
  logic [7:0] mask_two_reg;
  logic [`MASK_ONE_BITS-1:0] mask_one_reg;
  logic [7:0] mask_zero_reg;
  logic [`SRC_BITS-1:0] irq_status_reg;
  logic [`SRC_BITS-1:0] irq_mask_reg;

  // =====================================================================
  // pin sampling
  logic [`PIN_BITS-1:0] pin_raw;
  logic [`PIN_BITS-1:0] s1_reg;
  logic [`PIN_BITS-1:0] s2_reg;
  logic [`PIN_BITS-1:0] s3_reg;
  logic [`PIN_BITS-1:0] stable_reg;
  logic [`PIN_BITS-1:0] prev_reg;
  logic [`PIN_BITS-1:0] changed;

  // pins are read directly, whatever their port direction is set to
  assign pin_raw = {i_group_two_pins, i_group_one_pins, i_group_zero_pins,
                    i_ext_line_one, i_ext_line_zero};

  // three stages per pin; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_BITS; gi = gi + 1)
    begin : g_sync
      always_ff @(posedge i_core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_reg[gi] <= 1'b1;
          s2_reg[gi] <= 1'b1;
          s3_reg[gi] <= 1'b1;
          stable_reg[gi] <= 1'b1;
          prev_reg[gi] <= 1'b1;
        end
        else
        begin
          s1_reg[gi] <= pin_raw[gi];
          s2_reg[gi] <= s1_reg[gi];
          s3_reg[gi] <= s2_reg[gi];
          if (s2_reg[gi] == s3_reg[gi])
          begin
            stable_reg[gi] <= s3_reg[gi];
          end
          prev_reg[gi] <= stable_reg[gi];
        end
      end
    end
  endgenerate

  // edges come from two successive accepted samples
  assign changed = stable_reg ^ prev_reg;

  // =====================================================================
  // external line triggers
  sense_t sense_zero;
  sense_t sense_one;
  logic [1:0] line_level;
  logic [1:0] line_low;
  logic [1:0] line_edge;

  assign sense_zero = sense_t'(sense_control_reg[`SENSE_ZERO_LSB +: 2]);
  assign sense_one = sense_t'(sense_control_reg[`SENSE_ONE_LSB +: 2]);
  assign line_level[0] = (sense_zero == SENSE_LOW);
  assign line_level[1] = (sense_one == SENSE_LOW);
  assign line_low[0] = ~stable_reg[`PIN_LINE_ZERO];
  assign line_low[1] = ~stable_reg[`PIN_LINE_ONE];

  // edge match for each line against its selected sense
  function automatic logic edge_hit(input sense_t sel, input logic now,
                                    input logic chg);
    logic hit;
    hit = 1'b0;
    case (sel)
      SENSE_ANY: hit = chg;
      SENSE_FALL: hit = chg & ~now;
      SENSE_RISE: hit = chg & now;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : edge_hit

  assign line_edge[0] = edge_hit(sense_zero, stable_reg[`PIN_LINE_ZERO],
                                 changed[`PIN_LINE_ZERO]);
  assign line_edge[1] = edge_hit(sense_one, stable_reg[`PIN_LINE_ONE],
                                 changed[`PIN_LINE_ONE]);

  // =====================================================================
  // pin change group triggers
  logic [2:0] group_edge;

  // a pin counts when its mask bit and its group enable are both set
  assign group_edge[0] = group_enable_reg[`BIT_GROUP_ZERO]
                         & |(changed[`PIN_G0_MSB:`PIN_G0_LSB] & mask_zero_reg);
  assign group_edge[1] = group_enable_reg[`BIT_GROUP_ONE]
                         & |(changed[`PIN_G1_MSB:`PIN_G1_LSB] & mask_one_reg);
  assign group_edge[2] = group_enable_reg[`BIT_GROUP_TWO]
                         & |(changed[`PIN_G2_MSB:`PIN_G2_LSB] & mask_two_reg);

  // =====================================================================
  // bus slave
  logic addr_phase;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic wr_line_flags;
  logic wr_group_flags;
  logic rd_status;
  logic [31:0] rd_mux;
  logic [7:0] ofs;

  assign addr_phase = i_hsel & i_htrans[1] & i_hready;
  assign ofs = i_haddr[7:0];
  assign rd_status = addr_phase & ~i_hwrite & (i_haddr[31:8] == 24'h000000)
                     & (ofs == `OFS_IRQ_STATUS);
  assign wr_line_flags = wr_pend_reg & (wr_addr_reg == `OFS_LINE_FLAGS);
  assign wr_group_flags = wr_pend_reg & (wr_addr_reg == `OFS_GROUP_FLAGS);
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // read multiplexer; unused bits and unmapped slots read zero
  always_comb
  begin
    rd_mux = 32'h00000000;
    if (i_haddr[31:8] != 24'h000000)
      rd_mux = 32'h00000000;
    else if (ofs == `OFS_SENSE_CONTROL)
      rd_mux[`SENSE_BITS-1:0] = sense_control_reg;
    else if (ofs == `OFS_LINE_ENABLE)
      rd_mux[`LINE_BITS-1:0] = line_enable_reg;
    else if (ofs == `OFS_LINE_FLAGS)
      rd_mux[`LINE_BITS-1:0] = line_flags_reg & ~line_level;
    else if (ofs == `OFS_GROUP_ENABLE)
      rd_mux[`GROUP_BITS-1:0] = group_enable_reg;
    else if (ofs == `OFS_GROUP_FLAGS)
      rd_mux[`GROUP_BITS-1:0] = group_flags_reg;
    else if (ofs == `OFS_MASK_TWO)
      rd_mux[7:0] = mask_two_reg;
    else if (ofs == `OFS_MASK_ONE)
      rd_mux[`MASK_ONE_BITS-1:0] = mask_one_reg;
    else if (ofs == `OFS_MASK_ZERO)
      rd_mux[7:0] = mask_zero_reg;
    else if (ofs == `OFS_IRQ_STATUS)
      rd_mux[`SRC_BITS-1:0] = irq_status_reg;
    else if (ofs == `OFS_IRQ_MASK)
      rd_mux[`SRC_BITS-1:0] = irq_mask_reg;
    else if (ofs == `OFS_PIN_STATE)
      rd_mux[`PIN_BITS-1:0] = stable_reg;
  end

  // address phase capture; read data is registered for the data phase
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= `RST_BYTE;
      o_hrdata <= 32'h00000000;
    end
    else
    begin
      wr_pend_reg <= addr_phase & i_hwrite & (i_haddr[31:8] == 24'h000000);
      if (addr_phase)
      begin
        wr_addr_reg <= ofs;
      end
      if (addr_phase & ~i_hwrite)
      begin
        o_hrdata <= rd_mux;
      end
    end
  end

  // plain control registers, written in the data phase
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sense_control_reg <= `SENSE_BITS'(`RST_BYTE);
      line_enable_reg <= `LINE_BITS'(`RST_BYTE);
      group_enable_reg <= `GROUP_BITS'(`RST_BYTE);
      mask_two_reg <= `RST_BYTE;
      mask_one_reg <= `MASK_ONE_BITS'(`RST_BYTE);
      mask_zero_reg <= `RST_BYTE;
      irq_mask_reg <= `RST_SRC;
    end
    else if (wr_pend_reg)
    begin
      // only implemented bits are stored, the rest is dropped
      if (wr_addr_reg == `OFS_SENSE_CONTROL)
        sense_control_reg <= i_hwdata[`SENSE_BITS-1:0];
      else if (wr_addr_reg == `OFS_LINE_ENABLE)
        line_enable_reg <= i_hwdata[`LINE_BITS-1:0];
      else if (wr_addr_reg == `OFS_GROUP_ENABLE)
        group_enable_reg <= i_hwdata[`GROUP_BITS-1:0];
      else if (wr_addr_reg == `OFS_MASK_TWO)
        mask_two_reg <= i_hwdata[7:0];
      else if (wr_addr_reg == `OFS_MASK_ONE)
        mask_one_reg <= i_hwdata[`MASK_ONE_BITS-1:0];
      else if (wr_addr_reg == `OFS_MASK_ZERO)
        mask_zero_reg <= i_hwdata[7:0];
      else if (wr_addr_reg == `OFS_IRQ_MASK)
        irq_mask_reg <= i_hwdata[`SRC_BITS-1:0];
    end
  end

  // =====================================================================
  // flags: set wins over acknowledge and write-one clears
  logic [4:0] ack_hit;
  logic [1:0] line_flags_next;
  logic [2:0] group_flags_next;

  assign ack_hit[0] = i_ack_valid & (i_ack_src == SRC_LINE_ZERO);
  assign ack_hit[1] = i_ack_valid & (i_ack_src == SRC_LINE_ONE);
  assign ack_hit[2] = i_ack_valid & (i_ack_src == SRC_GROUP_ZERO);
  assign ack_hit[3] = i_ack_valid & (i_ack_src == SRC_GROUP_ONE);
  assign ack_hit[4] = i_ack_valid & (i_ack_src == SRC_GROUP_TWO);

  // level lines keep their flag at zero
  always_comb
  begin
    line_flags_next = line_flags_reg;
    line_flags_next = line_flags_next & ~ack_hit[1:0];
    if (wr_line_flags)
    begin
      line_flags_next = line_flags_next & ~i_hwdata[`LINE_BITS-1:0];
    end
    line_flags_next = line_flags_next | line_edge;
    line_flags_next = line_flags_next & ~line_level;
  end

  // group flags follow the same set and clear order
  always_comb
  begin
    group_flags_next = group_flags_reg & ~ack_hit[4:2];
    if (wr_group_flags)
    begin
      group_flags_next = group_flags_next & ~i_hwdata[`GROUP_BITS-1:0];
    end
    group_flags_next = group_flags_next | group_edge;
  end

  // flag storage
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      line_flags_reg <= `LINE_BITS'(`RST_BYTE);
      group_flags_reg <= `GROUP_BITS'(`RST_BYTE);
    end
    else
    begin
      line_flags_reg <= line_flags_next;
      group_flags_reg <= group_flags_next;
    end
  end

  // =====================================================================
  // requests to the core, one per source
  logic [1:0] line_req;

  // level lines request while low, edge lines while their flag stands
  assign line_req = (line_level & line_low) | (~line_level & line_flags_reg);
  assign o_req[1:0] = line_req & line_enable_reg & {2{i_global_int_en}};
  assign o_req[4:2] = group_flags_reg & group_enable_reg
                      & {3{i_global_int_en}};

  // =====================================================================
  // clockless wake: raw level lines while low, raw group pins against the last accepted sample
  logic [1:0] wake_level;
  logic [2:0] wake_group;

  assign wake_level[0] = line_level[0] & line_enable_reg[0] & ~i_ext_line_zero;
  assign wake_level[1] = line_level[1] & line_enable_reg[1] & ~i_ext_line_one;
  assign wake_group[0] = group_enable_reg[0]
                         & |((i_group_zero_pins ^ stable_reg[`PIN_G0_MSB:`PIN_G0_LSB])
                             & mask_zero_reg);
  assign wake_group[1] = group_enable_reg[1]
                         & |((i_group_one_pins ^ stable_reg[`PIN_G1_MSB:`PIN_G1_LSB])
                             & mask_one_reg);
  assign wake_group[2] = group_enable_reg[2]
                         & |((i_group_two_pins ^ stable_reg[`PIN_G2_MSB:`PIN_G2_LSB])
                             & mask_two_reg);
  assign o_async_wake = |wake_level | |wake_group;

  // =====================================================================
  // sticky event status, cleared by a read, set wins
  logic [4:0] events;
  logic [1:0] level_start;

  assign level_start = line_level & changed[1:0] & line_low;
  assign events = {group_edge, line_edge | level_start};

  // status register
  always_ff @(posedge i_core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status_reg <= `RST_SRC;
    end
    else if (rd_status)
    begin
      irq_status_reg <= events;
    end
    else
    begin
      irq_status_reg <= irq_status_reg | events;
    end
  end

  // level interrupt while any unmasked status bit stands
  assign o_irq = |(irq_status_reg & irq_mask_reg);

endmodule : ext_and_pin_change_irq

// ### bench/pin_source.sv
// board-side model of the two external lines and the 23 pin change pins
// assumes: the bench calls put or flip; each change lands just after a rising edge
`timescale 1ns/1ps
`include "ext_irq_map.svh"

module pin_source (
  input wire logic i_clk,
  output logic o_line_zero,
  output logic o_line_one,
  output logic [7:0] o_group_zero,
  output logic [6:0] o_group_one,
  output logic [7:0] o_group_two
);
  logic [24:0] pins_reg = 25'h1FFFFFF;

  // =====================================================================
  // pin levels, idle high
  assign o_line_zero = pins_reg[`PIN_LINE_ZERO];
  assign o_line_one = pins_reg[`PIN_LINE_ONE];
  assign o_group_zero = pins_reg[`PIN_G0_MSB:`PIN_G0_LSB];
  assign o_group_one = pins_reg[`PIN_G1_MSB:`PIN_G1_LSB];
  assign o_group_two = pins_reg[`PIN_G2_MSB:`PIN_G2_LSB];

  // a low level stays until the bench releases it
  task automatic put(input int idx, input logic lvl);
  begin
    @(posedge i_clk);
    pins_reg[idx] <= lvl;
  end
  endtask : put

  // toggles one pin
  task automatic flip(input int idx);
  begin
    put(idx, ~pins_reg[idx]);
  end
  endtask : flip
endmodule : pin_source

// ### bench/ext_and_pin_change_irq_chk.sv
// concurrent checks on the pin interrupt block, seeing only its top ports
// assumes: one clock domain; bus hready is tied to the block's hreadyout
`timescale 1ns/1ps

module ext_and_pin_change_irq_chk
  import ext_irq_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic o_hreadyout,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hresp,
  input wire logic i_ext_line_zero,
  input wire logic i_ext_line_one,
  input wire logic [7:0] i_group_zero_pins,
  input wire logic [6:0] i_group_one_pins,
  input wire logic [7:0] i_group_two_pins,
  input wire logic i_global_int_en,
  input wire logic i_ack_valid,
  input wire ext_irq_pkg::src_t i_ack_src,
  input wire logic [4:0] o_req,
  input wire logic o_irq
);
  logic [24:0] pins;
  logic [24:0] pins_last_reg;
  logic gie_last_reg;
  logic [2:0] quiet_reg;
  logic taken;
  logic evt;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);

  // =====================================================================
  // cycles since anything could move the requests, saturating at 7
  assign pins = {i_group_two_pins, i_group_one_pins, i_group_zero_pins, i_ext_line_one,
                 i_ext_line_zero};
  assign taken = i_hsel & i_htrans[1] & i_hready;
  assign evt = (pins != pins_last_reg) | taken | i_ack_valid | (i_global_int_en != gie_last_reg);

  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      pins_last_reg <= 25'h1FFFFFF;
      gie_last_reg <= 1'b0;
      quiet_reg <= 3'h0;
    end
    else
    begin
      pins_last_reg <= pins;
      gie_last_reg <= i_global_int_en;
      quiet_reg <= evt ? 3'h0 : ((quiet_reg == 3'h7) ? 3'h7 : quiet_reg + 3'h1);
    end
  end

  // =====================================================================
  // assertions
  chk_resp_okay: assert property (o_hresp == 1'b0)
    else $error("bus response not okay");
  chk_zero_wait: assert property (o_hreadyout == 1'b1)
    else $error("bus slave inserted a wait");
  chk_global_gate: assert property (!i_global_int_en |-> o_req == 5'h00)
    else $error("request with global flag off");
  chk_rdata_hold: assert property (!(taken && !i_hwrite) |=> $stable(o_hrdata))
    else $error("read data moved without a read");
  chk_reset_quiet: assert property ($rose(i_nrst) |-> (o_req == 5'h00 && !o_irq) [*3])
    else $error("request or interrupt right after reset");
  chk_req_quiet: assert property (quiet_reg == 3'h7 && !evt |=> $stable(o_req))
    else $error("request moved with no cause");
  chk_sync_min: assert property (quiet_reg == 3'h7 && pins[24:2] != pins_last_reg[24:2]
    && pins[1:0] == pins_last_reg[1:0] && !taken && !i_ack_valid
    && i_global_int_en == gie_last_reg |=> $stable(o_req))
    else $error("pin change reached request unsynchronised");
  chk_ack_clears: assert property (quiet_reg == 3'h7 && i_ack_valid
    && i_ack_src >= SRC_GROUP_ZERO |=> !o_req[$past(i_ack_src)])
    else $error("acknowledge did not clear request");

  cov_group_ack: cover property (i_ack_valid && i_ack_src == SRC_GROUP_TWO);
  cov_irq_up: cover property ($rose(o_irq));
  cov_line_req: cover property ($rose(o_req[1]));
endmodule : ext_and_pin_change_irq_chk

bind ext_and_pin_change_irq ext_and_pin_change_irq_chk u_chk (.*);

// ### bench/test_ext_and_pin_change_irq.sv
// self-checking bench for the external line and pin change interrupt block
// assumes: core files compiled first; 200 MHz clock; this bench is the only bus master
`timescale 1ns/1ps
`include "ext_irq_map.svh"
`define CHK(g, e) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("mismatch %0t got %0h exp %0h", $time, (g), (e)); \
    end \
  end

module test_ext_and_pin_change_irq;
  import ext_irq_pkg::*;

  typedef struct packed {
    logic [7:0] ofs;
    logic [31:0] rst;
    logic [31:0] wd;
    logic [31:0] rd;
  } row_t;

  // offset, reset value, written value, value read back
  row_t rows [11] = '{
    '{8'h00, 32'h0, 32'hFF, 32'h0F}, '{8'h04, 32'h0, 32'hFF, 32'h03},
    '{8'h08, 32'h0, 32'hFF, 32'h00}, '{8'h0C, 32'h0, 32'hFF, 32'h07},
    '{8'h10, 32'h0, 32'hFF, 32'h00}, '{8'h14, 32'h0, 32'hFF, 32'hFF},
    '{8'h18, 32'h0, 32'hFF, 32'h7F}, '{8'h1C, 32'h0, 32'hFF, 32'hFF},
    '{8'h24, 32'h0, 32'hFF, 32'h1F}, '{8'h28, 32'h1FFFFFF, 32'hFF, 32'h1FFFFFF},
    '{8'h30, 32'h0, 32'hFF, 32'h00}};

  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic gie = 1'b0;
  logic ack_valid = 1'b0;
  src_t ack_src = SRC_LINE_ZERO;
  logic hready;
  logic [31:0] hrdata;
  logic line_zero;
  logic line_one;
  logic [7:0] g0;
  logic [6:0] g1;
  logic [7:0] g2;
  logic [4:0] req;
  logic wake;
  logic irq;
  logic [31:0] rv;
  logic [31:0] exp_v;
  int lsb;
  int errors = 0;
  int num_checks = 0;

  // =====================================================================
  // clock, design and pin source
  always #2.5 clk = ~clk;

  ext_and_pin_change_irq dut (
    .i_core_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hrdata(hrdata), .o_hresp(), .i_ext_line_zero(line_zero),
    .i_ext_line_one(line_one), .i_group_zero_pins(g0), .i_group_one_pins(g1),
    .i_group_two_pins(g2), .i_global_int_en(gie), .i_ack_valid(ack_valid),
    .i_ack_src(ack_src), .o_req(req), .o_async_wake(wake), .o_irq(irq));

  pin_source src (.i_clk(clk), .o_line_zero(line_zero), .o_line_one(line_one),
    .o_group_zero(g0), .o_group_one(g1), .o_group_two(g2));

  // =====================================================================
  // one single-word transfer, address phase then data phase
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] q);
  begin
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
  end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
  begin
    bus(a, 1'b1, d, rv);
    #1;
  end
  endtask : wr

  task automatic rd_is(input logic [7:0] a, input logic [31:0] e);
  begin
    bus(a, 1'b0, 32'h0, rv);
    `CHK(rv, e)
  end
  endtask : rd_is

  task automatic settle;
  begin
    repeat (10) @(posedge clk);
  end
  endtask : settle

  // one-cycle service acknowledge
  task automatic ack(input src_t s);
  begin
    @(posedge clk);
    ack_valid <= 1'b1;
    ack_src <= s;
    @(posedge clk);
    ack_valid <= 1'b0;
    #1;
  end
  endtask : ack

  task automatic test_done;
  begin
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask : test_done

  // =====================================================================
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end

  // main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (rows[i])
    begin
      rd_is(rows[i].ofs, rows[i].rst);
      wr(rows[i].ofs, rows[i].wd);
      rd_is(rows[i].ofs, rows[i].rd);
      wr(rows[i].ofs, 32'h0);
    end
    // edge senses on each line, one edge at a time
    @(posedge clk);
    gie <= 1'b1;
    wr(`OFS_LINE_ENABLE, 32'h3);
    for (int l = 0; l < 2; l++)
    begin
      for (int m = 1; m < 4; m++)
      begin
        wr(`OFS_SENSE_CONTROL, 32'(m * 5));
        src.put(l, 1'b0);
        settle;
        exp_v = (m != 3) ? 32'(1 << l) : 32'h0;
        rd_is(`OFS_LINE_FLAGS, exp_v);
        `CHK(req[l], exp_v[l])
        wr(`OFS_LINE_FLAGS, 32'h0);
        rd_is(`OFS_LINE_FLAGS, exp_v);
        wr(`OFS_LINE_FLAGS, 32'h3);
        src.put(l, 1'b1);
        settle;
        exp_v = (m != 2) ? 32'(1 << l) : 32'h0;
        rd_is(`OFS_LINE_FLAGS, exp_v);
        wr(`OFS_LINE_FLAGS, 32'h3);
        rd_is(`OFS_LINE_FLAGS, 32'h0);
      end
    end
    // two-cycle pulse in any-change mode, the shortest the filter must keep
    wr(`OFS_SENSE_CONTROL, 32'h5);
    src.put(1, 1'b0);
    @(posedge clk);
    src.put(1, 1'b1);
    settle;
    rd_is(`OFS_LINE_FLAGS, 32'h2);
    ack(SRC_LINE_ONE);
    `CHK(req, 5'h00)
    rd_is(`OFS_LINE_FLAGS, 32'h0);
    // low level on line zero
    wr(`OFS_SENSE_CONTROL, 32'h0);
    src.put(0, 1'b0);
    settle;
    `CHK(req, 5'h01)
    `CHK(wake, 1'b1)
    rd_is(`OFS_LINE_FLAGS, 32'h0);
    ack(SRC_LINE_ZERO);
    `CHK(req, 5'h01)
    @(posedge clk);
    gie <= 1'b0;
    #1;
    `CHK(req, 5'h00)
    @(posedge clk);
    gie <= 1'b1;
    wr(`OFS_LINE_ENABLE, 32'h0);
    `CHK(req, 5'h00)
    `CHK(wake, 1'b0)
    src.put(0, 1'b1);
    settle;
    `CHK(wake, 1'b0)
    // pin change groups: group gate, pin mask, flag, acknowledge
    for (int g = 0; g < 3; g++)
    begin
      lsb = (g == 0) ? `PIN_G0_LSB : ((g == 1) ? `PIN_G1_LSB : `PIN_G2_LSB);
      wr(`OFS_GROUP_ENABLE, 32'h0);
      wr(8'h1C - 8'(g * 4), 32'h1);
      src.flip(lsb);
      settle;
      rd_is(`OFS_GROUP_FLAGS, 32'h0);
      wr(`OFS_GROUP_ENABLE, 32'(1 << g));
      src.flip(lsb + 1);
      settle;
      rd_is(`OFS_GROUP_FLAGS, 32'h0);
      settle;
      src.flip(lsb);
      #1;
      `CHK(wake, 1'b1)
      settle;
      `CHK(wake, 1'b0)
      `CHK(req, 5'(4 << g))
      ack(src_t'(g + 2));
      `CHK(req, 5'h00)
      rd_is(`OFS_GROUP_FLAGS, 32'h0);
    end
    // status, mask and interrupt line
    wr(`OFS_IRQ_MASK, 32'h0);
    bus(`OFS_IRQ_STATUS, 1'b0, 32'h0, rv);
    src.flip(`PIN_G2_LSB);
    settle;
    `CHK(irq, 1'b0)
    wr(`OFS_IRQ_MASK, 32'h10);
    `CHK(irq, 1'b1)
    rd_is(`OFS_IRQ_STATUS, 32'h10);
    #1;
    `CHK(irq, 1'b0)
    // reset in mid-run: outputs drop at once, registers reload
    @(posedge clk);
    nrst <= 1'b0;
    #1;
    `CHK(req, 5'h00)
    `CHK(irq, 1'b0)
    `CHK(hrdata, 32'h0)
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd_is(`OFS_GROUP_ENABLE, 32'h0);
    rd_is(`OFS_GROUP_FLAGS, 32'h0);
    test_done;
  end
endmodule : test_ext_and_pin_change_irq
